// file: common/plx_pkg.sv
// Package: encodings, field positions and reset values for the executor
package plx_pkg;
   localparam logic [7:0] OP_ADDPTR = 8'hE8;
   localparam logic [5:0] OP_INCREMENT_FILE_REGISTER = 6'h0A;
   localparam logic [7:0] OP_JMP1 = 8'hEF;
   localparam logic [3:0] OP_JMP2 = 4'hF;
   localparam int SEL_MSB = 7;
   localparam int SEL_LSB = 6;
   localparam logic [1:0] SEL_RET = 2'h3;
   localparam logic [1:0] PTR_TWO = 2'h2;
   localparam int LIT_MSB = 5;
   localparam int DEST_BIT = 9;
   localparam int ACC_BIT = 8;
   localparam logic [7:0] IDX_LIMIT = 8'h5F;
   localparam int PTR_W = 12;
   localparam int PC_W = 21;
   localparam int STK_DEPTH = 4;
   localparam logic [11:0] PTR_RST = 12'h000;
   localparam logic [20:0] PC_RST = 21'h000000;
   localparam logic [7:0] W_RST = 8'h00;
   localparam logic [4:0] STATUS_RST = 5'h00;
   typedef enum logic [1:0] {
      PLX_EXEC = 2'b00,
      PLX_RET_NOP = 2'b01,
      PLX_JMP_WAIT = 2'b11
   } plx_state_t;
endpackage : plx_pkg

// file: common/plx_file_if.sv
// Interface: data-file read and write port between core and file memory
`timescale 1ns/1ns
interface plx_file_if;
   logic [7:0] raddr;
   logic [7:0] rdata;
   logic we;
   logic [7:0] waddr;
   logic [7:0] wdata;
   modport core(output raddr, output we, output waddr, output wdata,
      input rdata);
   modport mem(input raddr, input we, input waddr, input wdata,
      output rdata);
endinterface : plx_file_if

// file: rtl/plx_file_mem.sv
// Small data-file memory with registered read data
`timescale 1ns/1ns
module plx_file_mem (
   input wire logic clk_i,
   plx_file_if.mem port
);
   // Cleared at power-up so that a first increment starts from a known value
   logic [7:0] mem_reg [0:255] = '{default: 8'h00};
   logic [7:0] rdata_reg;
   always_ff @(posedge clk_i) begin
      if (port.we) begin
         mem_reg[port.waddr] <= port.wdata;
      end
   end
   always_ff @(posedge clk_i) begin
      rdata_reg <= mem_reg[port.raddr];
   end
   assign port.rdata = rdata_reg;
endmodule : plx_file_mem

// file: rtl/plx_exec.sv
// Executor for pointer-add, add-and-return, increment and absolute jump
// How it works
// - The pointer add adds a 6-bit unsigned literal to pointer 0, 1 or 2 by the selector.
// - Selector value 11 means the add-and-return form, which targets pointer two only.
// - In the same cycle as the add to pointer two, add-and-return loads the PC from the return stack top.
// - Add-and-return takes two cycles, the second doing nothing at all.
// - With the extended set on and access form, increment indexes file addresses up to 95.
// - Increment adds one to the file register and writes to W or the file per the dest bit.
// - The absolute jump loads 20 bits into PC 20..1 over two words and two cycles.
`timescale 1ns/1ns
module plx_exec (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic instr_valid_i,
   input wire logic [15:0] instr_i,
   input wire logic ext_set_i,
   input wire logic stack_push_i,
   input wire logic [20:0] push_addr_i,
   output logic [11:0] ptr0_o,
   output logic [11:0] ptr1_o,
   output logic [11:0] ptr2_o,
   output logic [20:0] pc_o,
   output logic [7:0] w_o,
   output logic [4:0] status_o,
   output logic busy_o
);
   plx_file_if fport ();
   plx_file_mem u_mem (.clk_i(clk_i), .port(fport));

   plx_pkg::plx_state_t state_reg;
   logic [11:0] ptr_reg [0:2];
   logic [20:0] pc_reg;
   logic [7:0] w_reg;
   logic [4:0] status_reg;
   logic [20:0] stk_reg [0:plx_pkg::STK_DEPTH-1];
   logic [1:0] sp_reg;
   logic [7:0] jmp_lo_reg;
   logic inc_pend_reg;
   logic inc_dest_reg;
   logic [7:0] inc_addr_reg;

   logic take;
   logic is_addptr;
   logic is_ret;
   logic is_inc;
   logic is_jmp1;
   logic [1:0] sel;
   logic [5:0] lit;
   logic [7:0] f_field;
   logic [7:0] f_addr;
   logic [7:0] inc_sum;

   assign take = instr_valid_i && (state_reg == plx_pkg::PLX_EXEC);
   assign sel = instr_i[plx_pkg::SEL_MSB:plx_pkg::SEL_LSB];
   assign lit = instr_i[plx_pkg::LIT_MSB:0];
   assign f_field = instr_i[7:0];
   assign is_addptr = take && ext_set_i && instr_i[15:8] == plx_pkg::OP_ADDPTR;
   assign is_ret = is_addptr && sel == plx_pkg::SEL_RET;
   assign is_inc = take && instr_i[15:10] == plx_pkg::OP_INCREMENT_FILE_REGISTER;
   assign is_jmp1 = take && instr_i[15:8] == plx_pkg::OP_JMP1;

   // Indexed form: file offset is relative to pointer two
   always_comb begin
      f_addr = f_field;
      if (ext_set_i && !instr_i[plx_pkg::ACC_BIT]
          && f_field <= plx_pkg::IDX_LIMIT) begin
         f_addr = 8'(ptr_reg[2][7:0] + f_field);
      end
   end

   assign inc_sum = 8'(fport.rdata + 8'h01);
   assign fport.raddr = f_addr;
   assign fport.we = inc_pend_reg && inc_dest_reg;
   assign fport.waddr = inc_addr_reg;
   assign fport.wdata = inc_sum;

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_reg <= plx_pkg::PLX_EXEC;
      end else begin
         unique case (state_reg)
            plx_pkg::PLX_EXEC: begin
               if (is_ret) begin
                  state_reg <= plx_pkg::PLX_RET_NOP;
               end else if (is_jmp1) begin
                  state_reg <= plx_pkg::PLX_JMP_WAIT;
               end
            end
            plx_pkg::PLX_RET_NOP: state_reg <= plx_pkg::PLX_EXEC;
            plx_pkg::PLX_JMP_WAIT: begin
               if (instr_valid_i) begin
                  state_reg <= plx_pkg::PLX_EXEC;
               end
            end
            default: state_reg <= plx_pkg::PLX_EXEC;
         endcase
      end
   end

   // Pointer add; the return form always writes pointer two
   generate
      for (genvar i = 0; i < 3; i++) begin : g_ptr
         always_ff @(posedge clk_i) begin
            if (reset_i) begin
               ptr_reg[i] <= plx_pkg::PTR_RST;
            end else if (is_addptr && (is_ret ? i == 2 : sel == 2'(i))) begin
               ptr_reg[i] <= 12'(ptr_reg[i] + {6'h00, lit});
            end
         end
      end
   endgenerate

   // Return stack; pushes come from the call logic elsewhere in the core
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sp_reg <= 2'h0;
      end else if (is_ret) begin
         sp_reg <= 2'(sp_reg - 2'h1);
      end else if (stack_push_i) begin
         sp_reg <= 2'(sp_reg + 2'h1);
      end
   end

   always_ff @(posedge clk_i) begin
      if (stack_push_i && !is_ret) begin
         stk_reg[sp_reg] <= push_addr_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pc_reg <= plx_pkg::PC_RST;
      end else if (is_ret) begin
         pc_reg <= stk_reg[2'(sp_reg - 2'h1)];
      end else if (state_reg == plx_pkg::PLX_JMP_WAIT && instr_valid_i) begin
         pc_reg <= {instr_i[11:0], jmp_lo_reg, 1'b0};
      end else if (take) begin
         pc_reg <= 21'(pc_reg + 21'h2);
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         jmp_lo_reg <= 8'h00;
      end else if (is_jmp1) begin
         jmp_lo_reg <= instr_i[7:0];
      end
   end

   // Read data arrive one cycle later, so the write-back is staged
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         inc_pend_reg <= 1'b0;
         inc_dest_reg <= 1'b0;
         inc_addr_reg <= 8'h00;
      end else begin
         inc_pend_reg <= is_inc;
         inc_dest_reg <= instr_i[plx_pkg::DEST_BIT];
         inc_addr_reg <= f_addr;
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         w_reg <= plx_pkg::W_RST;
      end else if (inc_pend_reg && !inc_dest_reg) begin
         w_reg <= inc_sum;
      end
   end

   // Flags C DC Z OV N; the pointer add never touches them
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         status_reg <= plx_pkg::STATUS_RST;
      end else if (inc_pend_reg) begin
         status_reg <= {inc_sum[7], fport.rdata == 8'h7F, inc_sum == 8'h00,
            fport.rdata[3:0] == 4'hF, fport.rdata == 8'hFF};
      end
   end

   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         ptr0_o <= plx_pkg::PTR_RST;
         ptr1_o <= plx_pkg::PTR_RST;
         ptr2_o <= plx_pkg::PTR_RST;
         pc_o <= plx_pkg::PC_RST;
         w_o <= plx_pkg::W_RST;
         status_o <= plx_pkg::STATUS_RST;
         busy_o <= 1'b0;
      end else begin
         ptr0_o <= ptr_reg[0];
         ptr1_o <= ptr_reg[1];
         ptr2_o <= ptr_reg[2];
         pc_o <= pc_reg;
         w_o <= w_reg;
         status_o <= status_reg;
         busy_o <= state_reg != plx_pkg::PLX_EXEC;
      end
   end

   ptr_add_a: assert property (@(posedge clk_i) disable iff (reset_i)
      is_addptr && !is_ret && sel == 2'h1
      |=> ptr_reg[1] == 12'($past(ptr_reg[1]) + $past(lit)))
      else $error("pointer add wrong");
   ret_ptr2_a: assert property (@(posedge clk_i) disable iff (reset_i)
      is_ret |=> ptr_reg[2] == 12'($past(ptr_reg[2]) + $past(lit))
      && $stable(ptr_reg[0]) && $stable(ptr_reg[1]))
      else $error("return form hit wrong pointer");
   ret_pc_a: assert property (@(posedge clk_i) disable iff (reset_i)
      is_ret |=> pc_reg == $past(stk_reg[2'(sp_reg - 2'h1)]))
      else $error("return target wrong");
   ret_nop_a: assert property (@(posedge clk_i) disable iff (reset_i)
      is_ret |=> !take ##1 state_reg == plx_pkg::PLX_EXEC)
      else $error("return second cycle not idle");
   idx_addr_a: assert property (@(posedge clk_i) disable iff (reset_i)
      ext_set_i && !instr_i[8] && f_field <= 8'h5F
      |-> f_addr == 8'(ptr_reg[2][7:0] + f_field))
      else $error("indexed address wrong");
   flags_kept_a: assert property (@(posedge clk_i) disable iff (reset_i)
      is_addptr && !inc_pend_reg |=> $stable(status_reg))
      else $error("pointer add changed flags");
   inc_w_a: assert property (@(posedge clk_i) disable iff (reset_i)
      is_inc && !instr_i[9] ##1 1'b1 |=> w_reg == $past(inc_sum))
      else $error("increment to W wrong");
   jmp_pc_a: assert property (@(posedge clk_i) disable iff (reset_i)
      is_jmp1 ##1 instr_valid_i
      |=> pc_reg == {$past(instr_i[11:0]), $past(jmp_lo_reg), 1'b0})
      else $error("jump target wrong");
   ret_seen_c: cover property (@(posedge clk_i) is_ret);
   jmp_seen_c: cover property (@(posedge clk_i) is_jmp1 ##1 instr_valid_i);
   inc_seen_c: cover property (@(posedge clk_i) is_inc && instr_i[9]);
endmodule : plx_exec

// file: testbench/plx_exec_tb.sv
// Self-checking testbench for the pointer-add, increment and jump executor
`timescale 1ns/1ns
module testbench;
   logic clk_i;
   logic reset_i = 1'b1;
   logic instr_valid_i = 1'b0;
   logic [15:0] instr_i = 16'h0000;
   logic ext_set_i = 1'b0;
   logic stack_push_i = 1'b0;
   logic [20:0] push_addr_i = 21'h000000;
   logic [11:0] ptr0_o;
   logic [11:0] ptr1_o;
   logic [11:0] ptr2_o;
   logic [20:0] pc_o;
   logic [7:0] w_o;
   logic [4:0] status_o;
   logic busy_o;
   int error_cnt = 0;
   int cmp_count = 0;
   int cycles = 0;
   logic [11:0] exp_ptr [3] = '{12'h000, 12'h000, 12'h000};

   plx_exec uut (.clk_i(clk_i), .reset_i(reset_i),
      .instr_valid_i(instr_valid_i), .instr_i(instr_i),
      .ext_set_i(ext_set_i), .stack_push_i(stack_push_i),
      .push_addr_i(push_addr_i), .ptr0_o(ptr0_o), .ptr1_o(ptr1_o),
      .ptr2_o(ptr2_o), .pc_o(pc_o), .w_o(w_o), .status_o(status_o),
      .busy_o(busy_o));

   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   // The whole sequence needs about 51 cycles; a hang is cut at 2000
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 2000) begin
         error_cnt++;
         $display("Error at %0t: run did not finish", $time);
         close_out();
      end
   end

   task automatic close_out();
      $display("Comparisons %0d, errors %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : close_out

   task automatic chk(input logic [20:0] got, input logic [20:0] exp,
      input string what);
      cmp_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got,
            exp);
      end
   endtask : chk

   // Inputs always move 5 ns after a rising edge; waiting ends any word
   task automatic step(input int n);
      instr_valid_i = 1'b0;
      instr_i = 16'h0000;
      repeat (n) @(posedge clk_i);
      #5;
   endtask : step

   // Word stands over one edge; the next issue or step replaces it
   task automatic issue(input logic [15:0] w);
      instr_valid_i = 1'b1;
      instr_i = w;
      @(posedge clk_i);
      #5;
   endtask : issue

   function automatic logic [15:0] add_w(input logic [1:0] s,
      input logic [5:0] k);
      return {plx_pkg::OP_ADDPTR, s, k};
   endfunction : add_w

   function automatic logic [15:0] inc_w(input logic d, input logic [7:0] f);
      return {plx_pkg::OP_INCREMENT_FILE_REGISTER, d, 1'b0, f};
   endfunction : inc_w

   // Only the relative change is judged, so start contents do not matter
   task automatic test_incr();
      logic [7:0] w1;
      issue(inc_w(1'b0, 8'h15));
      step(3);
      w1 = w_o;
      chk({20'h0, ^w1 === 1'bx}, 21'h0, "w known");
      ext_set_i = 1'b1;
      issue(add_w(plx_pkg::PTR_TWO, 6'h10));
      exp_ptr[2] = exp_ptr[2] + 12'h010;
      issue(inc_w(1'b1, 8'h05));
      step(3);
      chk(21'(w_o), 21'(w1), "w after file dest");
      ext_set_i = 1'b0;
      issue(inc_w(1'b0, 8'h15));
      step(3);
      chk(21'(w_o), 21'(8'(w1 + 8'h01)), "indexed inc");
   endtask : test_incr

   task automatic test_ptr();
      logic [4:0] st;
      st = status_o;
      ext_set_i = 1'b1;
      for (int s = 0; s < 3; s++) begin
         issue(add_w(s[1:0], 6'h3F));
         exp_ptr[s] = exp_ptr[s] + 12'h03F;
      end
      ext_set_i = 1'b0;
      // Without the extended set the pointer add must be ignored
      issue(add_w(2'h1, 6'h01));
      step(3);
      chk(21'(ptr0_o), 21'(exp_ptr[0]), "ptr0 add");
      chk(21'(ptr1_o), 21'(exp_ptr[1]), "ptr1 add");
      chk(21'(ptr2_o), 21'(exp_ptr[2]), "ptr2 add");
      chk(21'(status_o), 21'(st), "status kept");
   endtask : test_ptr

   task automatic test_ret();
      stack_push_i = 1'b1;
      push_addr_i = 21'h01ABCE;
      step(1);
      stack_push_i = 1'b0;
      ext_set_i = 1'b1;
      issue(add_w(plx_pkg::SEL_RET, 6'h23));
      exp_ptr[2] = exp_ptr[2] + 12'h023;
      // This word falls in the idle second cycle and must do nothing
      issue(add_w(2'h0, 6'h01));
      chk(21'(busy_o), 21'h1, "busy in second cycle");
      chk(pc_o, 21'h01ABCE, "return pc");
      chk(21'(ptr2_o), 21'(exp_ptr[2]), "ptr2 return add");
      step(3);
      chk(21'(ptr0_o), 21'(exp_ptr[0]), "ptr0 untouched");
      chk(21'(ptr1_o), 21'(exp_ptr[1]), "ptr1 untouched");
      chk(pc_o, 21'h01ABCE, "pc held");
   endtask : test_ret

   task automatic test_jmp();
      issue({plx_pkg::OP_JMP1, 8'h3B});
      issue({plx_pkg::OP_JMP2, 12'hA5C});
      step(3);
      chk(pc_o, {20'hA5C3B, 1'b0}, "jump pc");
   endtask : test_jmp

   initial begin
      step(20);
      reset_i = 1'b0;
      chk(pc_o, 21'h0, "pc reset");
      chk(21'(ptr0_o), 21'h0, "ptr0 reset");
      chk(21'(ptr1_o), 21'h0, "ptr1 reset");
      chk(21'(ptr2_o), 21'h0, "ptr2 reset");
      chk(21'({w_o, status_o, busy_o}), 21'h0, "flags reset");
      test_incr();
      test_ptr();
      test_ret();
      test_jmp();
      close_out();
   end
endmodule : testbench
